// ===== rtl/idle_bus_drive.sv
// external bus drive: passes the core's bus, parks it while idle
// assumes the core's bus signals are on the same clock
module idle_bus_drive
  import irq_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic idle,
  input wire logic cpu_ale,
  input wire logic cpu_program_store_strobe_n_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic [7:0] cpu_ad_lo,
  input wire logic cpu_ad_lo_oe,
  input wire logic [7:0] cpu_addr_hi,
  output logic ale,
  output logic program_store_strobe_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] ad_lo_out,
  output logic ad_lo_oe,
  output logic [7:0] addr_hi
);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ale <= 1'b0;
      program_store_strobe_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      ad_lo_out <= BUS_IDLE_BYTE;
      ad_lo_oe <= 1'b0;
      addr_hi <= BUS_IDLE_BYTE;
    end else if (clk_en) begin
      if (idle) begin
        ale <= 1'b0; // see (R17)
        program_store_strobe_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        ad_lo_out <= BUS_IDLE_BYTE;
        ad_lo_oe <= 1'b1;
        addr_hi <= BUS_IDLE_BYTE;
      end else begin
        ale <= cpu_ale;
        program_store_strobe_n <= cpu_program_store_strobe_n_n;
        rd_n <= cpu_rd_n;
        wr_n <= cpu_wr_n;
        ad_lo_out <= cpu_ad_lo;
        ad_lo_oe <= cpu_ad_lo_oe;
        addr_hi <= cpu_addr_hi;
      end
    end
  end

endmodule

// ===== rtl/irq_controller_idle_wake.sv
// interrupt controller with idle mode and wake-up for an 8-bit core
// assumes requests come from peripherals on other clocks (synchronised
// here) and that ack and return strobes come from the core's clock
//
// Operation
// (R1) one enable bit per source
// (R2) global enable off blocks every acknowledge
// (R3) debug first in polling, vector 0063
// (R4) ext0, timer0, ext1 follow in order
// (R5) timer1, uart0, timer2 pair follow next
// (R6) spi, reserved slot, then i2c follow
// (R7) adc, counter array, uart1 close the order
// (R8) main enable register bit layout
// (R9) extra enable register bit layout
// (R10) main level register bit layout
// (R11) extra level register bit layout
// (R12) high preempts low, nothing preempts high
// (R13) higher level first, then polling order
// (R14) idle halts core, state kept intact
// (R15) peripherals keep running during idle
// (R16) ports and listed peripherals stay active
// (R17) idle parks external bus at fixed levels
// (R18) enabled interrupt clears idle and wakes
// (R19) external reset held two machine cycles
// (R20) internal reset restarts after three cycles
// (R21) request, vector, in-service until return
// (R22) enable and level registers reset zero
module irq_controller_idle_wake
  import irq_ctrl_pkg::*;
#(
  parameter int CLOCKS_PER_MC = CLOCKS_PER_MACHINE_CYCLE
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic [NUM_SLOTS-1:0] src_req,
  output logic irq_req,
  output logic [VEC_W-1:0] irq_vector,
  output logic irq_level,
  input wire logic irq_ack,
  input wire logic return_from_irq,
  input wire logic internal_reset,
  output logic cpu_halt,
  output logic cpu_restart_hold,
  output logic peripheral_run,
  input wire logic cpu_ale,
  input wire logic cpu_program_store_strobe_n_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic [7:0] cpu_ad_lo,
  input wire logic cpu_ad_lo_oe,
  input wire logic [7:0] cpu_addr_hi,
  output logic ale,
  output logic program_store_strobe_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] ad_lo_out,
  output logic ad_lo_oe,
  output logic [7:0] addr_hi
);

  localparam int RESTART_CLOCKS = RESTART_MACHINE_CYCLES * CLOCKS_PER_MC;
  localparam int CNT_W = $clog2(RESTART_CLOCKS + 1);
  localparam logic [CNT_W-1:0] RESTART_LAST = CNT_W'(RESTART_CLOCKS - 1);

  logic [7:0] irq_enable_main_reg;
  logic [7:0] irq_enable_extra_reg;
  logic [7:0] irq_level_main_reg;
  logic [7:0] irq_level_extra_reg;
  logic [7:0] power_control_reg;

  logic [NUM_SLOTS-1:0] req_meta_reg;
  logic [NUM_SLOTS-1:0] req_sync_reg;

  logic [1:0] in_service_reg; // bit 1 high level, bit 0 low level
  logic ack_reg;
  logic [DATA_W-1:0] readdata_reg;

  power_state_e state_reg;
  logic [CNT_W-1:0] restart_cnt_reg;

  logic [7:0] reg_index;
  logic access;
  logic wr_take;
  logic rd_take;
  logic [NUM_SLOTS-1:0] slot_enable;
  logic [NUM_SLOTS-1:0] slot_level;
  logic [NUM_SLOTS-1:0] pending;
  logic allow_high;
  logic allow_low;
  logic pick_found;
  logic [SLOT_W-1:0] pick_slot;
  logic pick_level;
  logic wake;
  logic idle_clear;

  // bus decode; one wait cycle gives a registered answer
  assign reg_index = address[ADDR_W-1:2];
  assign access = read | write;
  assign waitrequest = access & ~(ack_reg & clk_en);
  assign wr_take = write & ~read & ack_reg & byteenable[0] & clk_en;
  assign rd_take = read & ~write & ~ack_reg & clk_en;
  assign readdata = readdata_reg;

  function automatic logic [7:0] masked_write(
    input logic [7:0] data,
    input logic [7:0] mask
  );
    masked_write = data & mask;
  endfunction

  // the ack toggles off after one cycle so back-to-back accesses each wait
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= access & ~ack_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readdata_reg <= '0;
    end else if (rd_take) begin
      case (reg_index)
        IDX_ENABLE_MAIN: readdata_reg <= {24'h000000, irq_enable_main_reg};
        IDX_ENABLE_EXTRA: readdata_reg <= {24'h000000, irq_enable_extra_reg};
        IDX_LEVEL_MAIN: readdata_reg <= {24'h000000, irq_level_main_reg};
        IDX_LEVEL_EXTRA: readdata_reg <= {24'h000000, irq_level_extra_reg};
        IDX_POWER: readdata_reg <= {24'h000000, power_control_reg};
        default: readdata_reg <= '0;
      endcase
    end
  end

  // reserved bits are masked so they read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_enable_main_reg <= REG_RESET; // see (R22)
      irq_enable_extra_reg <= REG_RESET;
    end else if (wr_take) begin
      if (reg_index == IDX_ENABLE_MAIN) begin
        irq_enable_main_reg <=
          masked_write(writedata[7:0], ENABLE_MAIN_MASK); // see (R8)
      end
      if (reg_index == IDX_ENABLE_EXTRA) begin
        irq_enable_extra_reg <=
          masked_write(writedata[7:0], ENABLE_EXTRA_MASK); // see (R9)
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_level_main_reg <= REG_RESET; // see (R22)
      irq_level_extra_reg <= REG_RESET;
    end else if (wr_take) begin
      if (reg_index == IDX_LEVEL_MAIN) begin
        irq_level_main_reg <=
          masked_write(writedata[7:0], LEVEL_MAIN_MASK); // see (R10)
      end
      if (reg_index == IDX_LEVEL_EXTRA) begin
        irq_level_extra_reg <=
          masked_write(writedata[7:0], LEVEL_EXTRA_MASK); // see (R11)
      end
    end
  end

  // peripheral flags live on the oscillator clock, so synchronise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_meta_reg <= '0;
      req_sync_reg <= '0;
    end else if (clk_en) begin
      req_meta_reg <= src_req;
      req_sync_reg <= req_meta_reg;
    end
  end

  // map register bits onto slots in polling order
  always_comb begin
    slot_enable = '0;
    slot_level = '0;
    slot_enable[SLOT_DEBUG] = irq_enable_main_reg[BIT_DEBUG]; // see (R3)
    slot_enable[SLOT_EXT0] = irq_enable_main_reg[BIT_EXT0]; // see (R4)
    slot_enable[SLOT_TIMER0] = irq_enable_main_reg[BIT_TIMER0];
    slot_enable[SLOT_EXT1] = irq_enable_main_reg[BIT_EXT1];
    slot_enable[SLOT_TIMER1] = irq_enable_main_reg[BIT_TIMER1]; // see (R5)
    slot_enable[SLOT_UART0] = irq_enable_main_reg[BIT_UART0];
    slot_enable[SLOT_TIMER2] = irq_enable_main_reg[BIT_TIMER2];
    slot_enable[SLOT_SPI] = irq_enable_extra_reg[BIT_SPI]; // see (R6)
    slot_enable[SLOT_RSVD] = 1'b0;
    slot_enable[SLOT_I2C] = irq_enable_extra_reg[BIT_I2C];
    slot_enable[SLOT_ADC] = irq_enable_extra_reg[BIT_ADC]; // see (R7)
    slot_enable[SLOT_CARRAY] = irq_enable_extra_reg[BIT_CARRAY];
    slot_enable[SLOT_UART1] = irq_enable_extra_reg[BIT_UART1];
    slot_level[SLOT_DEBUG] = irq_level_main_reg[BIT_DEBUG]; // see (R12)
    slot_level[SLOT_EXT0] = irq_level_main_reg[BIT_EXT0];
    slot_level[SLOT_TIMER0] = irq_level_main_reg[BIT_TIMER0];
    slot_level[SLOT_EXT1] = irq_level_main_reg[BIT_EXT1];
    slot_level[SLOT_TIMER1] = irq_level_main_reg[BIT_TIMER1];
    slot_level[SLOT_UART0] = irq_level_main_reg[BIT_UART0];
    slot_level[SLOT_TIMER2] = irq_level_main_reg[BIT_TIMER2];
    slot_level[SLOT_SPI] = irq_level_extra_reg[BIT_SPI];
    slot_level[SLOT_I2C] = irq_level_extra_reg[BIT_I2C];
    slot_level[SLOT_ADC] = irq_level_extra_reg[BIT_ADC];
    slot_level[SLOT_CARRAY] = irq_level_extra_reg[BIT_CARRAY];
    slot_level[SLOT_UART1] = irq_level_extra_reg[BIT_UART1];
  end

  // per-source enable gated by the global enable
  assign pending = req_sync_reg & slot_enable
    & {NUM_SLOTS{irq_enable_main_reg[BIT_GLOBAL]}}; // see (R1) (R2)

  // a high routine blocks all; a low routine admits only high requests
  assign allow_high = ~in_service_reg[1]; // see (R12)
  assign allow_low = ~in_service_reg[1] & ~in_service_reg[0];

  irq_pick u_pick (
    .pending(pending),
    .level(slot_level),
    .allow_high(allow_high),
    .allow_low(allow_low),
    .found(pick_found),
    .slot(pick_slot),
    .slot_level(pick_level)
  );

  // request is withheld from the second restart cycle on so the core is not interrupted
  // before it has come out of reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      irq_vector <= '0;
      irq_level <= 1'b0;
    end else if (clk_en) begin
      if (irq_ack) begin
        irq_req <= 1'b0;
      end else begin
        irq_req <= pick_found & (state_reg != RESTART); // see (R21)
        irq_vector <= slot_vector(pick_slot);
        irq_level <= pick_level;
      end
    end
  end

  // ack latches the level shown; return clears the most recent level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      in_service_reg <= 2'b00;
    end else if (clk_en) begin
      if (return_from_irq) begin
        if (in_service_reg[1]) begin
          in_service_reg[1] <= 1'b0; // see (R21)
        end else begin
          in_service_reg[0] <= 1'b0;
        end
      end
      if (irq_ack && irq_req) begin
        in_service_reg[irq_level] <= 1'b1; // see (R21)
      end
    end
  end

  // any enabled request wakes, preemption does not matter here
  assign wake = |pending; // see (R18)
  assign idle_clear = wake | internal_reset;

  // hardware clear beats a software set in the same cycle, so a
  // write that enters idle with a request pending falls straight through
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      power_control_reg <= REG_RESET;
    end else if (clk_en) begin
      if (idle_clear) begin
        power_control_reg[BIT_IDLE] <= 1'b0; // see (R18)
      end else if (wr_take && reg_index == IDX_POWER) begin
        power_control_reg <= masked_write(writedata[7:0], POWER_MASK);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= RUN;
      restart_cnt_reg <= '0;
    end else if (clk_en) begin
      case (state_reg)
        RUN: begin
          if (internal_reset) begin
            state_reg <= RESTART;
            restart_cnt_reg <= '0;
          end else if (power_control_reg[BIT_IDLE]) begin
            state_reg <= IDLE; // see (R14)
          end
        end
        IDLE: begin
          if (internal_reset) begin
            state_reg <= RESTART; // see (R20)
            restart_cnt_reg <= '0;
          end else if (!power_control_reg[BIT_IDLE]) begin
            state_reg <= RUN; // see (R18)
          end
        end
        RESTART: begin
          if (restart_cnt_reg == RESTART_LAST) begin
            state_reg <= RUN; // see (R20)
          end else begin
            restart_cnt_reg <= restart_cnt_reg + 1'b1;
          end
        end
        default: state_reg <= RUN;
      endcase
    end
  end

  // the core halts with its state frozen; it keeps all its own registers
  assign cpu_halt = (state_reg == IDLE); // see (R14)
  assign cpu_restart_hold = (state_reg == RESTART);

  // peripherals and port latches are stopped by this block only from reset until the first clk_en
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      peripheral_run <= 1'b0;
    end else if (clk_en) begin
      peripheral_run <= 1'b1; // see (R15) (R16)
    end
  end

  idle_bus_drive u_bus (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .idle(cpu_halt),
    .cpu_ale(cpu_ale),
    .cpu_program_store_strobe_n_n(cpu_program_store_strobe_n_n),
    .cpu_rd_n(cpu_rd_n),
    .cpu_wr_n(cpu_wr_n),
    .cpu_ad_lo(cpu_ad_lo),
    .cpu_ad_lo_oe(cpu_ad_lo_oe),
    .cpu_addr_hi(cpu_addr_hi),
    .ale(ale),
    .program_store_strobe_n(program_store_strobe_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .ad_lo_out(ad_lo_out),
    .ad_lo_oe(ad_lo_oe),
    .addr_hi(addr_hi)
  );

endmodule

// ===== rtl/irq_ctrl_pkg.sv
// constants shared by the interrupt controller and its helpers
// assumes one cpu clock domain that keeps running in idle
package irq_ctrl_pkg;

  localparam int NUM_SLOTS = 13;
  localparam int SLOT_W = 4;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int VEC_W = 16;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_POWER = 8'h87;
  localparam logic [7:0] IDX_ENABLE_EXTRA = 8'ha7;
  localparam logic [7:0] IDX_ENABLE_MAIN = 8'ha8;
  localparam logic [7:0] IDX_LEVEL_EXTRA = 8'hb7;
  localparam logic [7:0] IDX_LEVEL_MAIN = 8'hb8;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ENABLE_MAIN_MASK = 8'hff;
  localparam logic [7:0] ENABLE_EXTRA_MASK = 8'hf2;
  localparam logic [7:0] LEVEL_MAIN_MASK = 8'h7f;
  localparam logic [7:0] LEVEL_EXTRA_MASK = 8'hf2;
  localparam logic [7:0] POWER_MASK = 8'h01;

  // bit positions, main registers
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_DEBUG = 6;
  localparam int BIT_TIMER2 = 5;
  localparam int BIT_UART0 = 4;
  localparam int BIT_TIMER1 = 3;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_TIMER0 = 1;
  localparam int BIT_EXT0 = 0;
  // bit positions, extra registers
  localparam int BIT_ADC = 7;
  localparam int BIT_SPI = 6;
  localparam int BIT_CARRAY = 5;
  localparam int BIT_UART1 = 4;
  localparam int BIT_I2C = 1;
  // bit position in power_control
  localparam int BIT_IDLE = 0;

  // slots in polling order, slot 0 highest
  localparam int SLOT_DEBUG = 0;
  localparam int SLOT_EXT0 = 1;
  localparam int SLOT_TIMER0 = 2;
  localparam int SLOT_EXT1 = 3;
  localparam int SLOT_TIMER1 = 4;
  localparam int SLOT_UART0 = 5;
  localparam int SLOT_TIMER2 = 6;
  localparam int SLOT_SPI = 7;
  localparam int SLOT_RSVD = 8;
  localparam int SLOT_I2C = 9;
  localparam int SLOT_ADC = 10;
  localparam int SLOT_CARRAY = 11;
  localparam int SLOT_UART1 = 12;

  localparam logic [VEC_W-1:0] VEC_DEBUG = 16'h0063;
  localparam logic [VEC_W-1:0] VEC_EXT0 = 16'h0003;
  localparam logic [VEC_W-1:0] VEC_TIMER0 = 16'h000b;
  localparam logic [VEC_W-1:0] VEC_EXT1 = 16'h0013;
  localparam logic [VEC_W-1:0] VEC_TIMER1 = 16'h001b;
  localparam logic [VEC_W-1:0] VEC_UART0 = 16'h0023;
  localparam logic [VEC_W-1:0] VEC_TIMER2 = 16'h002b;
  localparam logic [VEC_W-1:0] VEC_SPI = 16'h0053;
  localparam logic [VEC_W-1:0] VEC_RSVD = 16'h0033;
  localparam logic [VEC_W-1:0] VEC_I2C = 16'h0043;
  localparam logic [VEC_W-1:0] VEC_ADC = 16'h003b;
  localparam logic [VEC_W-1:0] VEC_CARRAY = 16'h005b;
  localparam logic [VEC_W-1:0] VEC_UART1 = 16'h004b;

  localparam logic [7:0] BUS_IDLE_BYTE = 8'hff;
  localparam int RESTART_MACHINE_CYCLES = 3;
  localparam int CLOCKS_PER_MACHINE_CYCLE = 4;

  typedef enum logic [1:0] {
    RUN,
    IDLE,
    RESTART
  } power_state_e;

  function automatic logic [VEC_W-1:0] slot_vector(
    input logic [SLOT_W-1:0] slot
  );
    case (slot)
      4'h0: slot_vector = VEC_DEBUG;
      4'h1: slot_vector = VEC_EXT0;
      4'h2: slot_vector = VEC_TIMER0;
      4'h3: slot_vector = VEC_EXT1;
      4'h4: slot_vector = VEC_TIMER1;
      4'h5: slot_vector = VEC_UART0;
      4'h6: slot_vector = VEC_TIMER2;
      4'h7: slot_vector = VEC_SPI;
      4'h8: slot_vector = VEC_RSVD;
      4'h9: slot_vector = VEC_I2C;
      4'ha: slot_vector = VEC_ADC;
      4'hb: slot_vector = VEC_CARRAY;
      default: slot_vector = VEC_UART1;
    endcase
  endfunction

endpackage

// ===== rtl/irq_pick.sv
// picks the winning request: level first, then polling order
// assumes pending and level vectors are already in slot order
module irq_pick
  import irq_ctrl_pkg::*;
(
  input wire logic [NUM_SLOTS-1:0] pending,
  input wire logic [NUM_SLOTS-1:0] level,
  input wire logic allow_high,
  input wire logic allow_low,
  output logic found,
  output logic [SLOT_W-1:0] slot,
  output logic slot_level
);

  // lowest set bit is the earliest slot in the polling order
  function automatic logic [SLOT_W-1:0] first_set(
    input logic [NUM_SLOTS-1:0] v
  );
    first_set = '0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = SLOT_W'(i);
      end
    end
  endfunction

  logic [NUM_SLOTS-1:0] high_req;
  logic [NUM_SLOTS-1:0] low_req;

  always_comb begin
    high_req = pending & level & {NUM_SLOTS{allow_high}};
    low_req = pending & ~level & {NUM_SLOTS{allow_low}};
    found = 1'b0;
    slot = '0;
    slot_level = 1'b0;
    if (|high_req) begin // see (R13)
      found = 1'b1;
      slot = first_set(high_req); // see (R3)
      slot_level = 1'b1;
    end else if (|low_req) begin
      found = 1'b1;
      slot = first_set(low_req); // see (R13)
    end
  end

endmodule

// ===== test/cpu_core_model.sv
// behavioural core: takes vectors and returns from service routines
// assumes the bench calls its tasks right after a rising edge
module cpu_core_model
  import irq_ctrl_pkg::*;
(
  input logic clock,
  input logic irq_req,
  input logic [VEC_W-1:0] irq_vector,
  input logic irq_level,
  output logic irq_ack,
  output logic return_from_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    irq_ack = 1'b0;
    return_from_irq = 1'b0;
  end

  // dly lets the core answer promptly or slowly
  task automatic take(input int dly, output logic [VEC_W-1:0] v,
                      output logic l);
    while (irq_req !== 1'b1) begin
      @(posedge clock);
    end
    repeat (dly) @(posedge clock);
    irq_ack <= 1'b1;
    @(posedge clock);
    v = irq_vector;
    l = irq_level;
    irq_ack <= 1'b0;
  endtask

  // the wait lets a dropped source clear the synchroniser first
  task automatic give_back();
    repeat (4) @(posedge clock);
    return_from_irq <= 1'b1;
    @(posedge clock);
    return_from_irq <= 1'b0;
  endtask
endmodule

// ===== test/irq_controller_idle_wake_tb.sv
// self-checking bench: registers, polling order, levels, idle, restart
// assumes the monitor is bound to the design by its own file
module irq_controller_idle_wake_tb
  import irq_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPM = 2;
  logic clock, rst_n, clk_en, read, write, irq_req, irq_level, irq_ack;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata, d;
  logic [3:0] byteenable;
  logic waitrequest, return_from_irq, internal_reset, cpu_halt;
  logic cpu_restart_hold, peripheral_run, ale, program_store_strobe_n;
  logic [NUM_SLOTS-1:0] src_req;
  logic [VEC_W-1:0] irq_vector, v;
  logic rd_n, wr_n, ad_lo_oe, l, seen;
  logic [7:0] ad_lo_out, addr_hi, pat;
  int err_count, checks_done, n;
  logic [9:0] adr [4] = '{10'h29c, 10'h2a0, 10'h2dc, 10'h2e0};
  logic [7:0] msk [4] = '{8'hf2, 8'hff, 8'hf2, 8'h7f};
  logic [15:0] vt [13] = '{16'h0063, 16'h0003, 16'h000b, 16'h0013,
    16'h001b, 16'h0023, 16'h002b, 16'h0053, 16'h0033, 16'h0043,
    16'h003b, 16'h005b, 16'h004b};

  irq_controller_idle_wake #(.CLOCKS_PER_MC(CPM))
    irq_controller_idle_wake_inst (
    .clock, .rst_n, .clk_en, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .src_req, .irq_req, .irq_vector,
    .irq_level, .irq_ack, .return_from_irq, .internal_reset, .cpu_halt,
    .cpu_restart_hold, .peripheral_run, .cpu_ale(pat[0]),
    .cpu_program_store_strobe_n_n(pat[1]), .cpu_rd_n(pat[2]), .cpu_wr_n(pat[3]),
    .cpu_ad_lo(pat), .cpu_ad_lo_oe(pat[4]), .cpu_addr_hi(~pat), .ale,
    .program_store_strobe_n, .rd_n, .wr_n, .ad_lo_out, .ad_lo_oe, .addr_hi);
  cpu_core_model cpu_core_model_inst (.clock, .irq_req, .irq_vector,
    .irq_level, .irq_ack, .return_from_irq);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // moving core bus so the pass-through and parking are both visible
  always @(posedge clock) pat <= pat + 8'h1b;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [9:0] a, input logic wr,
                     input logic [7:0] wd, output logic [31:0] rdat);
    address <= a;
    writedata <= {24'h0, wd};
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rdat = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] wd);
    logic [31:0] x;
    bus(a, 1'b1, wd, x);
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic serve(input logic [15:0] ev, input logic el);
    cpu_core_model_inst.take(n % 3, v, l);
    chk(v, ev);
    chk(l, el);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    complete_run();
  end

  initial begin
    {rst_n, read, write, internal_reset, seen} = '0;
    {clk_en, byteenable, address, writedata, src_req, pat} = {5'h1f, 63'h0};
    err_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      bus(adr[i], 1'b0, 8'h00, d);
      chk(d, 32'h0);
      wr(adr[i], 8'hff);
      bus(adr[i], 1'b0, 8'h00, d);
      chk(d, {24'h0, msk[i]});
    end
    wr(10'h004, 8'hff);
    bus(10'h004, 1'b0, 8'h00, d);
    chk(d, 32'h0);
    $display("test registers done");
    wr(10'h2a0, 8'h7f);
    wr(10'h2dc, 8'h00);
    wr(10'h2e0, 8'h00);
    src_req <= 13'h1eff;
    repeat (10) begin
      @(posedge clock);
      seen |= irq_req;
    end
    chk(seen, 1'b0);
    src_req <= 13'h0006;
    wr(10'h2a0, 8'hfe);
    serve(16'h000b, 1'b0);
    src_req <= 13'h0000;
    cpu_core_model_inst.give_back();
    wr(10'h2a0, 8'hff);
    src_req <= 13'h1eff;
    for (n = 0; n < 13; n++) begin
      if (n != 8) begin
        serve(vt[n], 1'b0);
        src_req[n] <= 1'b0;
        cpu_core_model_inst.give_back();
      end
    end
    $display("test polling order done");
    wr(10'h2dc, 8'h10);
    src_req <= 13'h1002;
    serve(16'h004b, 1'b1);
    src_req <= 13'h0003;
    seen = 1'b0;
    repeat (10) begin
      @(posedge clock);
      seen |= irq_req;
    end
    chk(seen, 1'b0);
    cpu_core_model_inst.give_back();
    serve(16'h0063, 1'b0);
    wr(10'h2e0, 8'h02);
    src_req <= 13'h0006;
    serve(16'h000b, 1'b1);
    src_req <= 13'h0002;
    cpu_core_model_inst.give_back();
    cpu_core_model_inst.give_back();
    serve(16'h0003, 1'b0);
    src_req <= 13'h0000;
    cpu_core_model_inst.give_back();
    $display("test levels done");
    wr(10'h21c, 8'h01);
    repeat (3) @(posedge clock);
    chk(cpu_halt, 1'b1);
    chk({ale, program_store_strobe_n, rd_n, wr_n, ad_lo_out, ad_lo_oe,
         addr_hi}, {4'b0111, 8'hff, 1'b1, 8'hff});
    chk(peripheral_run, 1'b1);
    src_req <= 13'h0004;
    repeat (6) @(posedge clock);
    chk(cpu_halt, 1'b0);
    bus(10'h21c, 1'b0, 8'h00, d);
    chk(d, 32'h0);
    serve(16'h000b, 1'b1);
    src_req <= 13'h0000;
    cpu_core_model_inst.give_back();
    $display("test idle done");
    internal_reset <= 1'b1;
    @(posedge clock);
    internal_reset <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge clock);
      if (cpu_restart_hold === 1'b1) n++;
    end
    chk(n, 3 * CPM);
    $display("test restart done");
    complete_run();
  end
endmodule

// ===== test/irq_ctrl_monitor.sv
// concurrent checks on the interrupt controller's top ports
// assumes one clock domain, synchronous active-low reset
module irq_ctrl_monitor
  import irq_ctrl_pkg::*;
#(
  parameter int CLOCKS_PER_MC = 4
)
(
  input logic clock,
  input logic rst_n,
  input logic clk_en,
  input logic irq_req,
  input logic [VEC_W-1:0] irq_vector,
  input logic irq_level,
  input logic irq_ack,
  input logic return_from_irq,
  input logic cpu_halt,
  input logic cpu_restart_hold,
  input logic cpu_ale,
  input logic cpu_rd_n,
  input logic [7:0] cpu_ad_lo,
  input logic [7:0] cpu_addr_hi,
  input logic ale,
  input logic program_store_strobe_n,
  input logic rd_n,
  input logic wr_n,
  input logic [7:0] ad_lo_out,
  input logic ad_lo_oe,
  input logic [7:0] addr_hi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hi_busy;
  logic lo_busy;
  logic [7:0] hold_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // shadow of the in-service levels, as the core sees them
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hi_busy <= 1'b0;
      lo_busy <= 1'b0;
    end else if (clk_en && irq_ack && irq_req) begin
      if (irq_level) hi_busy <= 1'b1;
      else lo_busy <= 1'b1;
    end else if (clk_en && return_from_irq) begin
      if (hi_busy) hi_busy <= 1'b0;
      else lo_busy <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !cpu_restart_hold) hold_cnt <= 8'h00;
    else if (clk_en) hold_cnt <= hold_cnt + 8'h01;
  end

  a_ack_drops_req: assert property (
    irq_ack && irq_req && clk_en |=> !irq_req)
    else $error("request stayed up after acknowledge");
  a_high_blocks_all: assert property (hi_busy |-> !irq_req)
    else $error("request while high level in service");
  a_low_needs_high: assert property (
    lo_busy && !hi_busy && irq_req |-> irq_level)
    else $error("low request while low level in service");
  a_vector_listed: assert property (
    irq_req |-> irq_vector inside {16'h0063, 16'h0003, 16'h000b, 16'h0013,
    16'h001b, 16'h0023, 16'h002b, 16'h0053, 16'h0043, 16'h003b, 16'h005b,
    16'h004b})
    else $error("request carries an unlisted vector");
  a_halt_parks_bus: assert property (cpu_halt && clk_en |=>
    !ale && program_store_strobe_n && rd_n && wr_n && ad_lo_out == 8'hff &&
    ad_lo_oe && addr_hi == 8'hff)
    else $error("bus not parked while halted");
  // pins still show reset values one edge after release
  a_bus_follows_core: assert property (
    rst_n && !cpu_halt && clk_en |=>
    ale == $past(cpu_ale) && rd_n == $past(cpu_rd_n) &&
    ad_lo_out == $past(cpu_ad_lo) && addr_hi == $past(cpu_addr_hi))
    else $error("bus pins do not follow the core");
  a_wake_ends_halt: assert property (
    cpu_halt && irq_req |-> ##[1:3] !cpu_halt)
    else $error("enabled request did not end idle");
  a_restart_length: assert property ($fell(cpu_restart_hold) |->
    hold_cnt == 8'(3 * CLOCKS_PER_MC))
    else $error("restart hold has wrong length");
  a_restart_no_req: assert property (
    cpu_restart_hold ##1 cpu_restart_hold |-> !irq_req)
    else $error("request during restart");

  c_ack: cover property (irq_ack && irq_req && irq_level);
  c_halt: cover property (cpu_halt ##1 !cpu_halt);
  c_restart: cover property ($fell(cpu_restart_hold));
endmodule

bind irq_controller_idle_wake irq_ctrl_monitor #(
  .CLOCKS_PER_MC(CLOCKS_PER_MC)
) mon_inst (.clock, .rst_n, .clk_en, .irq_req, .irq_vector, .irq_level,
  .irq_ack, .return_from_irq, .cpu_halt, .cpu_restart_hold, .cpu_ale,
  .cpu_rd_n, .cpu_ad_lo, .cpu_addr_hi, .ale, .program_store_strobe_n,
  .rd_n, .wr_n, .ad_lo_out, .ad_lo_oe, .addr_hi);
